/* src/tsfc_regs.svh */
// Purpose: Register indices, field positions, reset values and frame counts
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef TSFC_REGS_SVH
`define TSFC_REGS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define TSFC_IDX_CLK_SHARE 8'h10
`define TSFC_IDX_FP_CFG    8'h42
`define TSFC_IDX_MODE      8'h60
`define TSFC_IDX_STATUS    8'h61

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSFC_BIT_SHARE     1
`define TSFC_BIT_INVERT    1
`define TSFC_BIT_E1        2
`define TSFC_FLD_MODE_HI   1
`define TSFC_FLD_MODE_LO   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TSFC_RST_SHARE     1'h0
`define TSFC_RST_INVERT    1'h0
`define TSFC_RST_E1        1'h0
`define TSFC_RST_STATUS    8'h00

// ----------------------------------------------------------------
// Frame counts, last bit index of a frame
// ----------------------------------------------------------------
`define TSFC_T1_LAST       8'hC0
`define TSFC_E1_LAST       8'hFF

`endif

/* src/tsfc_pkg.sv */
// Purpose: Shared types of the transmit system frame and clock block
// Assumes: Constants live in tsfc_regs.svh
// Notes:   Types only
package tsfc_pkg;

  // ----------------------------------------------------------------
  // Timing modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSFC_MASTER = 2'b00,
    TSFC_SLAVE  = 2'b01,
    TSFC_MUX    = 2'b10,
    TSFC_RSVD   = 2'b11
  } tsfc_mode_t;

  // ----------------------------------------------------------------
  // Configuration carried into the link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    tsfc_mode_t mode;
    logic       e1;
    logic       invert;
    logic       share;
  } tsfc_cfg_t;

  // ----------------------------------------------------------------
  // Per-link controls into a framer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic master;
    logic tick;
    logic pulseIn;
  } tsfc_lctl_t;

endpackage

/* src/tsfc_sync.sv */
// Purpose: Two flip-flop level synchroniser
// Assumes: Inputs are levels or slow toggles
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module tsfc_sync #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clk,
  // Data
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] stab_d;

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = din;
    stab_d = meta_q;
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    dout   <= stab_d;
  end

endmodule
`default_nettype wire

/* src/tsfc_link_framer.sv */
// Purpose: One link frame counter, frame pulse and gapped clock
// Assumes: Runs on the link clock; tick marks a bit time in slave mode, half a bit time in master mode
// Notes:   Pulse held for one governing clock cycle
`timescale 1ns/10ps
`default_nettype none

`include "tsfc_regs.svh"

module tsfc_link_framer (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Controls
  input  wire tsfc_pkg::tsfc_lctl_t ctl,
  input  wire logic               e1,
  input  wire logic               invert,
  // Pins
  output var  logic               pulseOut,
  output var  logic               pulseOeN,
  output var  logic               clkOut,
  output var  logic               clkOeN,
  // Events
  output var  logic               frameTgl,
  output var  logic               slipTgl
);
  import tsfc_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] last;
  logic       bitEdge;
  logic       pulseOut_d;
  logic       pulseOeN_d;
  logic       clkOut_d;
  logic       clkOeN_d;
  logic       frameTgl_d;
  logic       slipTgl_d;
  logic       active;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    last       = e1 ? `TSFC_E1_LAST : `TSFC_T1_LAST;
    active     = ctl.pulseIn ^ invert;
    cnt_d      = cnt_q;
    pulseOut_d = pulseOut;
    clkOut_d   = 1'h0;
    frameTgl_d = frameTgl;
    slipTgl_d  = slipTgl;
    pulseOeN_d = ~ctl.master;
    clkOeN_d   = ~ctl.master;
    bitEdge    = 1'h0;
    if (ctl.master) begin
      clkOut_d = ctl.tick ? ~clkOut : clkOut;
      bitEdge  = ctl.tick & ~clkOut;
      if (bitEdge) begin
        cnt_d      = (cnt_q == last) ? 8'h00 : cnt_q + 8'h01;
        pulseOut_d = invert ^ (cnt_q == 8'h00);
        if (cnt_q == 8'h00) begin
          frameTgl_d = ~frameTgl;
        end
      end
    end else begin
      pulseOut_d = invert;
      bitEdge    = ctl.tick;
      if (bitEdge) begin
        if (active) begin
          cnt_d      = 8'h01;
          frameTgl_d = ~frameTgl;
          if (cnt_q != 8'h00) begin
            slipTgl_d = ~slipTgl;
          end
        end else begin
          cnt_d = (cnt_q == last) ? 8'h00 : cnt_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q    <= 8'h00;
      pulseOut <= 1'h0;
      pulseOeN <= 1'h1;
      clkOut   <= 1'h0;
      clkOeN   <= 1'h1;
      frameTgl <= 1'h0;
      slipTgl  <= 1'h0;
    end else if (ce) begin
      cnt_q    <= cnt_d;
      pulseOut <= pulseOut_d;
      pulseOeN <= pulseOeN_d;
      clkOut   <= clkOut_d;
      clkOeN   <= clkOeN_d;
      frameTgl <= frameTgl_d;
      slipTgl  <= slipTgl_d;
    end
  end

endmodule
`default_nettype wire

/* src/tsfc_top.sv */
// Purpose: Transmit system side frame pulse and clock timing, four links
// Assumes: APB on mclk; link logic on txSysClock (link 1 or multiplexed clock)
// Notes:   Link 1 pins double as the multiplexed pins
`timescale 1ns/10ps
`default_nettype none
`include "tsfc_regs.svh"

// Overview of operation
// - T1 master mode: device drives frame pulse at each framing bit or multiframe start.
// - E1 master mode: device drives frame pulse at frame or multiframe boundary.
// - Frame pulse launched or captured on its link's active system clock edge.
// - Polarity bit b1 of register 042H selects frame pulse active level.
// - Multiplexed pulse captured on multiplexed clock, polarity from same bit.
// - Master mode: device outputs gapped per-link clock, updates pulse on it.
// - Share bit b1 of register 010H makes link 1 clock serve all links in slave mode; master and multiplexed modes ignore it.
module tsfc_top (
  // System clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic [9:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Link clock: link 1 system clock or multiplexed clock
  input  wire logic        txSysClock,
  // Slave clocks of links 2 to 4
  input  wire logic [2:0]  txSysClockIn,
  // Master clock gaps from the line side
  input  wire logic [3:0]  txGapEn,
  // Frame pulse pins, link 1 also multiplexed
  input  wire logic [3:0]  txSysFramePulseIn,
  output var  logic [3:0]  txSysFramePulseOut,
  output var  logic [3:0]  txSysFramePulseOeN,
  // Clock pins in master mode
  output var  logic [3:0]  txSysClockOut,
  output var  logic [3:0]  txSysClockOeN
);
  import tsfc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  tsfc_cfg_t   cfg_q;
  tsfc_cfg_t   cfg_d;
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;
  logic        setup;
  logic        access;
  logic        hit;
  logic [31:0] rdata;
  logic [7:0]  index;
  logic [7:0]  evtSet;

  // ----------------------------------------------------------------
  // Crossing from link domain
  // ----------------------------------------------------------------
  logic [7:0]  lnkTgl;
  logic [7:0]  tglSync;
  logic [7:0]  tglSeen_q;
  logic [7:0]  tglSeen_d;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic [6:0]  cfgSync;
  tsfc_cfg_t   lnkCfg;
  logic        lnkRst;
  logic        lnkCe;
  logic [5:0]  pinSync;
  logic [2:0]  clkPrev_q;
  logic [2:0]  clkPrev_d;
  logic [2:0]  clkRise;
  logic [3:0]  pulseSmp;
  tsfc_lctl_t  lctl [3:0];
  tsfc_cfg_t   cfgPrev_q;
  tsfc_cfg_t   cfgPrev_d;
  tsfc_cfg_t   cfgHold_q;
  tsfc_cfg_t   cfgHold_d;
  logic [3:0]  slvTick;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & pready;
    index = paddr[9:2];
    hit = 1'h1;
    rdata = 32'h0000_0000;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'h0;
    end else if (index == `TSFC_IDX_CLK_SHARE) begin
      rdata[`TSFC_BIT_SHARE] = cfg_q.share;
    end else if (index == `TSFC_IDX_FP_CFG) begin
      rdata[`TSFC_BIT_INVERT] = cfg_q.invert;
    end else if (index == `TSFC_IDX_MODE) begin
      rdata[`TSFC_FLD_MODE_HI:`TSFC_FLD_MODE_LO] = cfg_q.mode;
      rdata[`TSFC_BIT_E1] = cfg_q.e1;
    end else if (index == `TSFC_IDX_STATUS) begin
      rdata[7:0] = status_q;
    end else begin
      hit = 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    status_d = status_q;
    pready_d = setup;
    pslverr_d = setup & ~hit;
    prdata_d = setup ? rdata : prdata;
    tglSeen_d = tglSync;
    evtSet = tglSync ^ tglSeen_q;
    if (access & pwrite & ~pslverr) begin
      if (index == `TSFC_IDX_CLK_SHARE) begin
        cfg_d.share = pwdata[`TSFC_BIT_SHARE];
      end else if (index == `TSFC_IDX_FP_CFG) begin
        cfg_d.invert = pwdata[`TSFC_BIT_INVERT];
      end else if (index == `TSFC_IDX_MODE) begin
        cfg_d.mode = tsfc_mode_t'(pwdata[`TSFC_FLD_MODE_HI:`TSFC_FLD_MODE_LO]);
        cfg_d.e1 = pwdata[`TSFC_BIT_E1];
      end else if (index == `TSFC_IDX_STATUS) begin
        status_d = status_q & ~pwdata[7:0];
      end
    end
    status_d = status_d | evtSet;
  end

  // ----------------------------------------------------------------
  // Register flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q.mode <= TSFC_SLAVE;
      cfg_q.e1 <= `TSFC_RST_E1;
      cfg_q.invert <= `TSFC_RST_INVERT;
      cfg_q.share <= `TSFC_RST_SHARE;
      status_q <= `TSFC_RST_STATUS;
      prdata <= 32'h0000_0000;
      pready <= 1'h0;
      pslverr <= 1'h0;
      tglSeen_q <= 8'h00;
    end else if (ce) begin
      cfg_q <= cfg_d;
      status_q <= status_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      tglSeen_q <= tglSeen_d;
    end
  end

  // ----------------------------------------------------------------
  // Link events into mclk
  // ----------------------------------------------------------------
  tsfc_sync #(.W(8)) u_evt_sync (
    .clk  (mclk),
    .din  (lnkTgl),
    .dout (tglSync)
  );

  // ----------------------------------------------------------------
  // Configuration, reset and enable into link domain
  // ----------------------------------------------------------------
  tsfc_sync #(.W(7)) u_cfg_sync (
    .clk  (txSysClock),
    .din  ({cfg_q, ce, rst}),
    .dout (cfgSync)
  );

  always_comb begin
    cfgPrev_d = tsfc_cfg_t'(cfgSync[6:2]);
    lnkCe = cfgSync[1];
    lnkRst = cfgSync[0];
  end

  // ----------------------------------------------------------------
  // Configuration word taken once two samples agree
  // ----------------------------------------------------------------
  always_comb begin
    cfgHold_d = cfgHold_q;
    if (cfgPrev_d == cfgPrev_q) begin
      cfgHold_d = cfgPrev_d;
    end
    lnkCfg = cfgHold_q;
  end

  always_ff @(posedge txSysClock) begin
    if (lnkRst) begin
      cfgPrev_q.mode <= TSFC_SLAVE;
      cfgPrev_q.e1 <= `TSFC_RST_E1;
      cfgPrev_q.invert <= `TSFC_RST_INVERT;
      cfgPrev_q.share <= `TSFC_RST_SHARE;
      cfgHold_q.mode <= TSFC_SLAVE;
      cfgHold_q.e1 <= `TSFC_RST_E1;
      cfgHold_q.invert <= `TSFC_RST_INVERT;
      cfgHold_q.share <= `TSFC_RST_SHARE;
    end else if (lnkCe) begin
      cfgPrev_q <= cfgPrev_d;
      cfgHold_q <= cfgHold_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock and pulse pins of links 2 to 4
  // ----------------------------------------------------------------
  tsfc_sync #(.W(6)) u_pin_sync (
    .clk  (txSysClock),
    .din  ({txSysClockIn, txSysFramePulseIn[3:1]}),
    .dout (pinSync)
  );

  always_comb begin
    clkPrev_d = pinSync[5:3];
    clkRise = pinSync[5:3] & ~clkPrev_q;
  end

  always_ff @(posedge txSysClock) begin
    if (lnkRst) begin
      clkPrev_q <= 3'h7;
    end else if (lnkCe) begin
      clkPrev_q <= clkPrev_d;
    end
  end

  // ----------------------------------------------------------------
  // Slave bit ticks, link 1 on every edge
  // ----------------------------------------------------------------
  always_comb begin
    slvTick = {clkRise, 1'h1};
  end

  // ----------------------------------------------------------------
  // Per-link controls
  // ----------------------------------------------------------------
  always_comb begin
    pulseSmp = {pinSync[2:0], txSysFramePulseIn[0]};
    for (int i = 0; i < 4; i++) begin
      lctl[i].master = 1'h0;
      lctl[i].tick = 1'h0;
      lctl[i].pulseIn = pulseSmp[i];
      case (lnkCfg.mode)
        TSFC_MASTER: begin
          lctl[i].master = 1'h1;
          lctl[i].tick = txGapEn[i];
        end
        TSFC_MUX: begin
          lctl[i].tick = (i == 0);
        end
        default: begin
          if (lnkCfg.share) begin
            lctl[i].tick = 1'h1;
          end else begin
            lctl[i].tick = slvTick[i];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Framers
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < 4; g++) begin : g_link
      tsfc_link_framer u_framer (
        .clk      (txSysClock),
        .rst      (lnkRst),
        .ce       (lnkCe),
        .ctl      (lctl[g]),
        .e1       (lnkCfg.e1),
        .invert   (lnkCfg.invert),
        .pulseOut (txSysFramePulseOut[g]),
        .pulseOeN (txSysFramePulseOeN[g]),
        .clkOut   (txSysClockOut[g]),
        .clkOeN   (txSysClockOeN[g]),
        .frameTgl (lnkTgl[g]),
        .slipTgl  (lnkTgl[g+4])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* verif/tsfc_properties.sv */
// Purpose: Port checks for tsfc_top
// Assumes: ce held high by the bench
// Notes:   Bound after endmodule
`timescale 1ns/10ps
`default_nettype none

module tsfc_properties (
  // Clocks and reset
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        txSysClock,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic [3:0]  txSysFramePulseOut,
  input wire logic [3:0]  txSysFramePulseOeN,
  input wire logic [3:0]  txSysClockOut,
  input wire logic [3:0]  txSysClockOeN
);
  // ------
  // Pulse edge spacing
  // ------
  logic       lvlQ;
  logic       chg;
  logic [9:0] gapQ;
  logic [1:0] armQ;
  assign chg = lvlQ != txSysFramePulseOut[0];
  always_ff @(posedge txSysClock) begin
    lvlQ <= txSysFramePulseOut[0];
    gapQ <= chg ? 10'h000 : gapQ + 10'h001;
    armQ <= (rst || txSysFramePulseOeN[0]) ? 2'h0 : (chg && armQ != 2'h2) ? armQ + 2'h1 : armQ;
  end

  // ------
  // Properties
  // ------
  property p_rdy_one;
    @(posedge mclk) disable iff (rst) pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");

  property p_rdy_setup;
    @(posedge mclk) disable iff (rst) psel && !penable && ce |=> pready;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no pready after setup");

  property p_rdy_acc;
    @(posedge mclk) disable iff (rst) pready |-> psel && penable;
  endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");

  property p_err_zero;
    @(posedge mclk) disable iff (rst) pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");

  property p_oe_pair;
    @(posedge txSysClock) disable iff (rst) txSysFramePulseOeN == txSysClockOeN;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("pin enables differ");

  property p_clk_idle;
    @(posedge txSysClock) disable iff (rst) txSysClockOeN[0] |-> !txSysClockOut[0];
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock out while released");

  property p_gap;
    @(posedge txSysClock) disable iff (rst)
      armQ == 2'h2 && chg && !txSysFramePulseOeN[0] |-> gapQ inside {10'h001, 10'h17F, 10'h1FD};
  endproperty
  a_gap: assert property (p_gap) else $error("pulse spacing wrong");

  property p_on_clk;
    @(posedge txSysClock) disable iff (rst)
      armQ == 2'h2 && chg && !txSysFramePulseOeN[0] |-> $rose(txSysClockOut[0]);
  endproperty
  a_on_clk: assert property (p_on_clk) else $error("pulse off clock edge");

  c_err: cover property (@(posedge mclk) pready && pslverr);
  c_ok: cover property (@(posedge mclk) pready && !pslverr);
  c_arm: cover property (@(posedge txSysClock) armQ == 2'h2 && chg);
endmodule

bind tsfc_top tsfc_properties u_props (
  .mclk(mclk), .rst(rst), .ce(ce), .txSysClock(txSysClock), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txSysFramePulseOut(txSysFramePulseOut), .txSysFramePulseOeN(txSysFramePulseOeN),
  .txSysClockOut(txSysClockOut), .txSysClockOeN(txSysClockOeN)
);
`default_nettype wire

/* verif/tsfc_sys_model.sv */
// Purpose: System side framer model driving frame pulses
// Assumes: One bit per link clock edge
// Notes:   Released pins read high through the pull-up
`timescale 1ns/10ps
`default_nettype none
`include "tsfc_regs.svh"

module tsfc_sys_model (
  // Link clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       drive,
  input  wire logic       e1,
  input  wire logic       invert,
  input  wire logic       slipTgl,
  // Pins toward the device
  output wire logic [3:0] pulse,
  output wire logic [2:0] clkIn
);
  logic [7:0] cntQ  = 8'h00;
  logic       slipQ = 1'b0;
  logic [3:0] fpQ   = 4'hF;
  logic [2:0] ckQ   = 3'h0;
  assign pulse = fpQ;
  assign clkIn = ckQ;
  // ------
  // Frame counter and pulse launch
  // ------
  always @(posedge clk) begin
    slipQ <= slipTgl;
    ckQ <= ~ckQ;
    if (slipQ != slipTgl) begin
      cntQ <= cntQ;
    end else if (rst || cntQ == (e1 ? `TSFC_E1_LAST : `TSFC_T1_LAST)) begin
      cntQ <= 8'h00;
    end else begin
      cntQ <= cntQ + 8'h01;
    end
    fpQ[0]   <= drive ? ((cntQ == 8'h00) ^ invert) : 1'b1;
    fpQ[3:1] <= drive ? {3{invert}} : 3'h7;
  end
endmodule
`default_nettype wire

/* verif/tsfc_top_tb_top.sv */
// Purpose: Self-checking bench of tsfc_top
// Assumes: ce held high; link clock 30 ns
// Notes:   Random register data and gap enables
`timescale 1ns/10ps
`default_nettype none
`include "tsfc_regs.svh"

module tsfc_top_tb_top;
  import tsfc_pkg::*;
  localparam logic [9:0] A_SH = {`TSFC_IDX_CLK_SHARE, 2'b00};
  localparam logic [9:0] A_FP = {`TSFC_IDX_FP_CFG, 2'b00};
  localparam logic [9:0] A_MD = {`TSFC_IDX_MODE, 2'b00};
  localparam logic [9:0] A_ST = {`TSFC_IDX_STATUS, 2'b00};
  logic        mclk = 1'b0, txSysClock = 1'b0, rst = 1'b1, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  txGapEn = 4'hF;
  logic        mDrive = 1'b1, mE1 = 1'b0, mInv = 1'b0, slipTgl = 1'b0;
  logic [2:0]  txSysClockIn;
  logic [3:0]  fpModel, fpPin, fpOut, fpOeN, ckOut, ckOeN;
  int          n_fail = 0, checked = 0, cyc = 0;
  assign fpPin = (fpOeN & fpModel) | (~fpOeN & fpOut);
  always #50 mclk = ~mclk;
  always #15 txSysClock = ~txSysClock;

  tsfc_top dut (
    .mclk(mclk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txSysClock(txSysClock), .txSysClockIn(txSysClockIn), .txGapEn(txGapEn),
    .txSysFramePulseIn(fpPin), .txSysFramePulseOut(fpOut), .txSysFramePulseOeN(fpOeN),
    .txSysClockOut(ckOut), .txSysClockOeN(ckOeN)
  );
  tsfc_sys_model u_sys (
    .clk(txSysClock), .rst(rst), .drive(mDrive), .e1(mE1), .invert(mInv),
    .slipTgl(slipTgl), .pulse(fpModel), .clkIn(txSysClockIn)
  );

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] expPer(input logic e);
    return 32'h2 * (32'(e ? `TSFC_E1_LAST : `TSFC_T1_LAST) + 32'h1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic waitLvl(input logic v, output int n);
    n = 0;
    do begin
      @(posedge txSysClock);
      n++;
    end while (fpOut[0] !== v && n < 1200);
  endtask
  task give_verdict;
    $display("TB: checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end

  // ------
  // Main sequence
  // ------
  initial begin
    int          s, w, p;
    logic [31:0] r, d;
    logic        e, e1m, inv;
    s = $urandom(93);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(A_SH, r);
    chk(r, 32'h0);
    rd(A_FP, r);
    chk(r, 32'h0);
    rd(A_MD, r);
    chk(r, 32'h1);
    apb(1'b1, 10'h3FC, 32'hFFFFFFFF, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 10'h3FC, 32'h0, r, e);
    chk(r, 32'h0);
    repeat (4) begin
      d = $urandom;
      wr(A_SH, d);
      wr(A_FP, d);
      rd(A_SH, r);
      chk(r, d & 32'h2);
      rd(A_FP, r);
      chk(r, d & 32'h2);
    end
    wr(A_SH, 32'h0);
    for (int k = 0; k < 4; k++) begin
      e1m = k[0];
      inv = k[1];
      wr(A_MD, {29'h0, e1m, 2'b01});
      wr(A_FP, {30'h0, inv, 1'b0});
      mE1 <= e1m;
      mInv <= inv;
      mDrive <= 1'b1;
      txGapEn <= 4'($urandom);
      repeat (200) @(posedge mclk);
      wr(A_ST, 32'hFF);
      repeat (200) @(posedge mclk);
      rd(A_ST, r);
      chk(r, 32'h1);
      slipTgl <= ~slipTgl;
      repeat (200) @(posedge mclk);
      rd(A_ST, r);
      chk(r, 32'h11);
      wr(A_MD, {29'h0, e1m, 2'b10});
      repeat (200) @(posedge mclk);
      wr(A_ST, 32'hFF);
      repeat (200) @(posedge mclk);
      rd(A_ST, r);
      chk(r, 32'h1);
      chk({28'h0, fpOeN}, 32'hF);
      chk({24'h0, fpOut, ckOut}, {24'h0, {4{inv}}, 4'h0});
      mDrive <= 1'b0;
      txGapEn <= 4'hF;
      wr(A_MD, {29'h0, e1m, 2'b00});
      repeat (20) @(posedge mclk);
      chk({24'h0, fpOeN, ckOeN}, 32'h0);
      waitLvl(inv, p);
      waitLvl(~inv, p);
      waitLvl(inv, w);
      waitLvl(~inv, p);
      chk(32'(w), 32'h2);
      chk(32'(w + p), expPer(e1m));
      wr(A_ST, 32'hFF);
      repeat (200) @(posedge mclk);
      rd(A_ST, r);
      chk(r, 32'hF);
    end
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(A_MD, r);
    chk(r, 32'h1);
    chk({28'h0, fpOeN}, 32'hF);
    give_verdict;
  end
endmodule
`default_nettype wire
